// *** sbc_boot_copy.sv ***
// Purpose: Copies the flash image to memory, then hands the flash to host
// Assumes: Single bus master, link clock unrelated to clk
// Notes: One read command per word; bytes arrive low byte first
`timescale 1ns/1ps
module sbc_boot_copy
    import sbc_pkg::*;
(
    input wire logic clk, // System and bus clock
    input wire logic rst_n, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic linkClk, // Flash link clock
    input wire logic power_on_reset_n, // Async power-on reset
    input wire logic external_reset_n, // Async external reset
    input wire logic copy_bypass_debug, // Skip copy when high at reset
    input wire logic cpu_reset_request, // Processor reset request
    output logic cpu_reset_n, // Processor reset
    output logic HRESETN, // Bus reset
    output logic [31:0] HADDR, // Bus address
    output logic [31:0] HWDATA, // Bus write data
    input wire logic [31:0] HRDATA, // Bus read data
    output logic HWRITE, // Bus write
    input wire logic HREADY, // Bus ready
    output logic [1:0] HTRANS, // Bus transfer type
    output logic [2:0] HSIZE, // Bus size
    output logic [2:0] HBURST, // Bus burst
    input wire logic HRESP, // Bus error response
    output logic [1:0] ahbErr, // Bus error flags
    output logic checksum_error_out, // Always low
    output logic flash_mosi_out, // Data to flash
    input wire logic flash_miso_in, // Data from flash
    output logic flash_cs_n, // Flash select
    output logic flash_sck, // Flash clock
    input wire logic host_mosi_in, // Host data to flash
    output logic host_miso_out, // Flash data to host
    input wire logic host_cs_n, // Host flash select
    input wire logic host_sck // Host flash clock
);
    // Clock domain signals
    sbc_state_t state;
    logic [15:0] recCnt;
    logic [15:0] wordIdx;
    logic [31:0] spiAddr;
    logic [31:0] dataWord;
    logic [31:0] firstData;
    logic readChecked;
    logic bootDone;
    logic dbgCap;
    logic reqTgl;
    logic doneD;
    logic porS;
    logic extS;
    logic dbgS;
    logic doneS;
    logic sysReset;
    logic linkRun;

    // Link domain signals
    sbc_link_state_t lstate;
    logic [3:0] div;
    logic [6:0] bitCnt;
    logic [31:0] deselCnt;
    logic [63:0] txShift;
    logic [31:0] rxShift;
    logic [31:0] rxWord;
    logic doneTgl;
    logic reqD;
    logic reqS;
    logic passL;
    logic ceL;
    logic rstL;
    logic misoS;
    logic hostCsS;
    logic hostSckS;
    logic hostMosiS;

    function automatic logic [31:0] byteSwap(input logic [31:0] w);
        byteSwap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction

    sbc_sync #(.WIDTH(4)) syncSys (
        .clk(clk),
        .d({power_on_reset_n, external_reset_n, copy_bypass_debug, doneTgl}),
        .q({porS, extS, dbgS, doneS})
    );

    sbc_sync #(.WIDTH(8)) syncLink (
        .clk(linkClk),
        .d({reqTgl, bootDone, ce, linkRun, flash_miso_in, host_cs_n,
            host_sck, host_mosi_in}),
        .q({reqS, passL, ceL, rstL, misoS, hostCsS, hostSckS, hostMosiS})
    );

    // Any reset source restarts the whole sequence
    assign sysReset = !rst_n || !porS || !extS || cpu_reset_request;

    // Every reset source also aborts the link, so no stale frame survives
    always_ff @(posedge clk) begin
        linkRun <= !sysReset;
    end

    always_ff @(posedge clk) begin
        if (sysReset) begin
            state <= ST_RESET;
            recCnt <= '0;
            wordIdx <= '0;
            spiAddr <= SBC_SPI_SRC_ADDR;
            dataWord <= SBC_WORD_RESET;
            firstData <= SBC_WORD_RESET;
            readChecked <= 1'b0;
            bootDone <= 1'b0;
            dbgCap <= dbgS;
            reqTgl <= 1'b0;
            doneD <= doneS;
            cpu_reset_n <= 1'b0;
            HRESETN <= 1'b0;
            HADDR <= SBC_AHB_DST_ADDR;
            HWDATA <= SBC_WORD_RESET;
            HWRITE <= 1'b0;
            HTRANS <= SBC_HTRANS_IDLE;
            HSIZE <= SBC_HSIZE_WORD;
            HBURST <= SBC_HBURST_SINGLE;
            ahbErr <= SBC_ERR_RESET;
            checksum_error_out <= 1'b0;
        end else if (ce) begin
            HRESETN <= 1'b1;
            doneD <= doneS;
            case (state)
                ST_RESET: begin
                    state <= ST_RECOVER;
                end
                ST_RECOVER: begin
                    recCnt <= recCnt + 16'h0001;
                    if (recCnt == SBC_RECOVERY_CYCLES - 16'h0001) begin
                        if (dbgCap) begin
                            state <= ST_DONE;
                        end else begin
                            reqTgl <= ~reqTgl;
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH: begin
                    if (doneS != doneD) begin
                        dataWord <= rxWord;
                        HTRANS <= SBC_HTRANS_NONSEQ;
                        HWRITE <= 1'b1;
                        state <= ST_WADDR;
                    end
                end
                ST_WADDR: begin
                    if (HREADY) begin
                        HTRANS <= SBC_HTRANS_IDLE;
                        HWDATA <= dataWord;
                        if (wordIdx == 16'h0000) begin
                            firstData <= dataWord;
                        end
                        state <= ST_WDATA;
                    end
                end
                ST_WDATA: begin
                    if (HRESP) begin
                        ahbErr[0] <= 1'b1;
                        state <= ST_ERROR;
                    end else if (HREADY) begin
                        if (!readChecked) begin
                            HTRANS <= SBC_HTRANS_NONSEQ;
                            HWRITE <= 1'b0;
                            state <= ST_RADDR;
                        end else begin
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_RADDR: begin
                    if (HREADY) begin
                        HTRANS <= SBC_HTRANS_IDLE;
                        state <= ST_RDATA;
                    end
                end
                ST_RDATA: begin
                    if (HRESP) begin
                        ahbErr[0] <= 1'b1;
                        state <= ST_ERROR;
                    end else if (HREADY) begin
                        readChecked <= 1'b1;
                        if (HRDATA != firstData) begin
                            ahbErr[1] <= 1'b1;
                            state <= ST_ERROR;
                        end else begin
                            state <= ST_NEXT;
                        end
                    end
                end
                ST_NEXT: begin
                    if (wordIdx == SBC_IMAGE_WORDS - 16'h0001) begin
                        state <= ST_DONE;
                    end else begin
                        wordIdx <= wordIdx + 16'h0001;
                        spiAddr <= spiAddr + SBC_ADDR_STEP;
                        HADDR <= HADDR + SBC_ADDR_STEP;
                        reqTgl <= ~reqTgl;
                        state <= ST_FETCH;
                    end
                end
                ST_DONE: begin
                    bootDone <= 1'b1;
                    cpu_reset_n <= 1'b1;
                end
                ST_ERROR: begin
                    cpu_reset_n <= 1'b0;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end

    // Flash link shifter; spiAddr is stable while a request is pending
    always_ff @(posedge linkClk) begin
        if (!rstL) begin
            lstate <= LK_IDLE;
            div <= '0;
            bitCnt <= '0;
            deselCnt <= '0;
            txShift <= '0;
            rxShift <= '0;
            rxWord <= '0;
            doneTgl <= 1'b0;
            reqD <= reqS;
            flash_cs_n <= 1'b1;
            flash_sck <= 1'b0;
            flash_mosi_out <= 1'b0;
            host_miso_out <= 1'b0;
        end else if (ceL) begin
            host_miso_out <= passL ? misoS : 1'b0;
            case (lstate)
                LK_IDLE: begin
                    if (passL) begin
                        flash_cs_n <= hostCsS;
                        flash_sck <= hostSckS;
                        flash_mosi_out <= hostMosiS;
                    end else if (reqS != reqD) begin
                        // Taken only here, so no request is lost mid-frame
                        reqD <= reqS;
                        txShift <= {SBC_READ_CMD, spiAddr[23:0], 32'h0000_0000};
                        flash_mosi_out <= SBC_READ_CMD[7];
                        flash_cs_n <= 1'b0;
                        flash_sck <= 1'b0;
                        div <= '0;
                        bitCnt <= '0;
                        lstate <= LK_SHIFT;
                    end else begin
                        flash_cs_n <= 1'b1;
                        flash_sck <= 1'b0;
                    end
                end
                LK_SHIFT: begin
                    if (div == SBC_SCK_HALF - 4'h1) begin
                        div <= '0;
                        if (!flash_sck) begin
                            flash_sck <= 1'b1;
                            rxShift <= {rxShift[30:0], misoS};
                        end else begin
                            flash_sck <= 1'b0;
                            if (bitCnt == SBC_FRAME_LAST) begin
                                flash_cs_n <= 1'b1;
                                rxWord <= byteSwap(rxShift);
                                doneTgl <= ~doneTgl;
                                deselCnt <= '0;
                                lstate <= LK_DESEL;
                            end else begin
                                bitCnt <= bitCnt + 7'h01;
                                txShift <= {txShift[62:0], 1'b0};
                                flash_mosi_out <= txShift[62];
                            end
                        end
                    end else begin
                        div <= div + 4'h1;
                    end
                end
                LK_DESEL: begin
                    deselCnt <= deselCnt + 32'h0000_0001;
                    if (deselCnt == SBC_DESELECT_CYCLES - 32'h0000_0001) begin
                        lstate <= LK_IDLE;
                    end
                end
                default: begin
                    lstate <= LK_IDLE;
                end
            endcase
        end
    end

    default clocking cbSys @(posedge clk);
    endclocking
    default disable iff (!rst_n || !ce);

    sequence wrAccepted;
        state == ST_WADDR && HREADY;
    endsequence

    sequence wrFailed;
        state == ST_WDATA && HRESP;
    endsequence

    cs_owned_a: assert property (@(posedge linkClk) disable iff (!rstL)
        (!passL && lstate == LK_IDLE) |=> flash_cs_n || lstate == LK_SHIFT)
        else $error("flash select driven without a command");
    pass_through_a: assert property (@(posedge linkClk) disable iff (!rstL)
        (ceL && passL && lstate == LK_IDLE) |=>
        flash_cs_n == $past(hostCsS) && flash_sck == $past(hostSckS))
        else $error("host pins not routed to flash");
    miso_return_a: assert property (@(posedge linkClk) disable iff (!rstL)
        (ceL && passL) |=> host_miso_out == $past(misoS))
        else $error("flash data not returned to host");
    deselect_gap_a: assert property (@(posedge linkClk)
        disable iff (!rstL || !ceL)
        ($rose(flash_cs_n) && !passL) |=> flash_cs_n [*7])
        else $error("flash select gap too short");
    cpu_hold_a: assert property (state != ST_DONE && !sysReset
        |=> !cpu_reset_n || $past(state) == ST_DONE)
        else $error("processor released before copy end");
    async_reset_a: assert property (disable iff (1'b0)
        !porS || !extS |=> state == ST_RESET && !cpu_reset_n)
        else $error("async reset not applied");
    debug_skip_a: assert property (state == ST_RECOVER && dbgCap &&
        recCnt == SBC_RECOVERY_CYCLES - 16'h0001 && !sysReset
        |=> state == ST_DONE ##1 cpu_reset_n || sysReset)
        else $error("debug mode did not skip copy");
    resp_error_a: assert property (wrFailed and !sysReset
        |=> ahbErr[0] && state == ST_ERROR)
        else $error("error response not flagged");
    readback_a: assert property (state == ST_RDATA && HREADY && !HRESP &&
        HRDATA != firstData && !sysReset |=> ahbErr[1])
        else $error("read-back mismatch not flagged");
    checksum_low_a: assert property (!checksum_error_out)
        else $error("checksum error output not low");
    error_hold_a: assert property (ahbErr[0] && !sysReset |=> !cpu_reset_n)
        else $error("processor released after bus error");
    sw_reset_a: assert property (disable iff (1'b0)
        cpu_reset_request |=> state == ST_RESET && !cpu_reset_n)
        else $error("software reset not applied");
    wr_phase_a: assert property (wrAccepted and !sysReset
        |=> HTRANS == SBC_HTRANS_IDLE && state == ST_WDATA)
        else $error("write address phase not closed");
endmodule

// *** sbc_boot_copy_tb_top.sv ***
// Purpose: Self-checking bench for the SPI boot copy port block
// Assumes: Partner model stands in for the flash and the bus memory
// Notes: Data from a fixed-seed xorshift; fault cases picked by hand
`timescale 1ns/1ps
module sbc_boot_copy_tb_top
    import sbc_pkg::*;
;
    logic clk, linkClk, rst_n, ce, power_on_reset_n, external_reset_n;
    logic copy_bypass_debug, cpu_reset_request, cpu_reset_n, HRESETN;
    logic [31:0] HADDR, HWDATA, HRDATA, seed, lastCmdExp, hAddrHold;
    logic HWRITE, HREADY, HRESP, checksum_error_out, slow, badRead;
    logic [1:0] HTRANS, ahbErr;
    logic [2:0] HSIZE, HBURST, fp;
    logic flash_mosi_out, flash_miso_in, flash_cs_n, flash_sck;
    logic host_mosi_in, host_miso_out, host_cs_n, host_sck;
    logic [5:0] errWord;
    logic [31:0] img [0:15];
    int error_cnt, n_checks, hiCnt, frames, nTr;

    assign fp = {flash_mosi_out, flash_cs_n, flash_sck};
    assign lastCmdExp = {SBC_READ_CMD, 24'(SBC_SPI_SRC_ADDR
                         + 32'(SBC_IMAGE_WORDS - 16'h1) * SBC_ADDR_STEP)};

    sbc_boot_copy sbc_boot_copy_i (.clk, .rst_n, .ce, .linkClk,
        .power_on_reset_n, .external_reset_n, .copy_bypass_debug,
        .cpu_reset_request, .cpu_reset_n, .HRESETN, .HADDR, .HWDATA,
        .HRDATA, .HWRITE, .HREADY, .HTRANS, .HSIZE, .HBURST, .HRESP,
        .ahbErr, .checksum_error_out, .flash_mosi_out, .flash_miso_in,
        .flash_cs_n, .flash_sck, .host_mosi_in, .host_miso_out,
        .host_cs_n, .host_sck);
    sbc_partner sbc_partner_i (.clk, .HRESETN, .HADDR, .HWDATA, .HWRITE,
        .HTRANS, .HRDATA, .HREADY, .HRESP, .slow, .errWord, .badRead,
        .flash_mosi_out, .flash_cs_n, .flash_sck, .flash_miso_in);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Odd offset keeps the link clock out of phase with clk
    initial begin
        linkClk = 1'b0;
        #1.7;
        forever #3 linkClk = ~linkClk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want,
                       input string what);
        n_checks++;
        if (got !== want) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, want);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge linkClk) begin
        if (flash_cs_n === 1'b1) begin
            hiCnt++;
        end else begin
            if (hiCnt > 0 && cpu_reset_n === 1'b0) begin
                frames++;
                chk(32'(hiCnt >= SBC_DESELECT_CYCLES), 32'h1, "gap");
                chk(32'(host_miso_out), 32'h0, "host data early");
            end
            hiCnt = 0;
        end
    end
    always @(posedge clk) begin
        if (HTRANS === 2'h2 && HREADY === 1'b1) nTr++;
    end

    task automatic fresh(input bit newImg);
        for (int k = 0; k < 16; k++) begin
            if (newImg) img[k] = rnd();
            sbc_partner_i.rom[k] = img[k];
            sbc_partner_i.ram[k] = 32'h0;
        end
        frames = 0;
        nTr = 0;
    endtask

    task automatic boot_reset(input logic dbg);
        @(negedge clk);
        rst_n = 1'b0;
        copy_bypass_debug = dbg;
        fresh(1);
        repeat (16) @(negedge clk);
        chk(32'(flash_cs_n), 32'h1, "select idle");
        chk(32'(cpu_reset_n), 32'h0, "cpu held");
        rst_n = 1'b1;
        @(negedge clk);
        copy_bypass_debug = 1'b0;
    endtask

    // Host pins toggle at random while the copy owns the flash
    task automatic wait_boot(input bit noise);
        for (int i = 0; i < 4000 && cpu_reset_n !== 1'b1; i++) begin
            @(negedge clk);
            if (noise) {host_mosi_in, host_cs_n, host_sck} = 3'(rnd());
        end
        chk(32'(cpu_reset_n), 32'h1, "cpu released");
    endtask

    task automatic check_image();
        for (int k = 0; k < 16; k++) begin
            chk(sbc_partner_i.ram[k], img[k], "image word");
        end
        chk(32'(frames), 32'(SBC_IMAGE_WORDS), "frames");
        chk(32'(nTr), 32'(SBC_IMAGE_WORDS) + 1, "transfers");
        chk(sbc_partner_i.lastCmd, lastCmdExp, "last command");
        chk(32'(ahbErr), 32'h0, "no bus error");
        chk(32'(checksum_error_out), 32'h0, "checksum");
    endtask

    task automatic pass_through();
        logic [2:0] hp;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk);
            hp = 3'(rnd());
            {host_mosi_in, host_cs_n, host_sck} = hp;
            repeat (2) @(negedge clk);
            chk(32'(fp), 32'(hp), "host to flash");
            chk(32'(host_miso_out), 32'(flash_miso_in), "to host");
        end
        host_cs_n = 1'b1;
    endtask

    task automatic wait_err(input logic [1:0] want);
        for (int i = 0; i < 3000 && ahbErr === 2'h0; i++) @(negedge clk);
        repeat (50) @(negedge clk);
        chk(32'(ahbErr), 32'(want), "error flags");
        chk(32'(cpu_reset_n), 32'h0, "cpu kept in reset");
    endtask

    task automatic sw_reset();
        @(negedge clk);
        cpu_reset_request = 1'b1;
        @(negedge clk);
        cpu_reset_request = 1'b0;
        // Cleared after the reset edge, so an aborted transfer is not counted
        fresh(0);
        @(negedge clk);
        chk(32'(cpu_reset_n), 32'h0, "software reset");
        chk(32'(ahbErr), 32'h0, "flags cleared");
    endtask

    initial begin
        {rst_n, copy_bypass_debug, cpu_reset_request, slow, badRead} = 5'h0;
        {ce, power_on_reset_n, external_reset_n} = 3'h7;
        {host_mosi_in, host_cs_n, host_sck} = 3'h2;
        errWord = 6'h3F;
        seed = 32'h6118;
        boot_reset(0);
        wait_boot(1);
        check_image();
        $display("test boot done");
        pass_through();
        $display("test pass-through done");
        slow = 1'b1;
        boot_reset(0);
        repeat (300) @(negedge clk);
        ce = 1'b0;
        hAddrHold = HADDR;
        repeat (20) @(negedge clk);
        chk(HADDR, hAddrHold, "frozen address");
        chk(32'(cpu_reset_n), 32'h0, "cpu held frozen");
        ce = 1'b1;
        sw_reset();
        wait_boot(1);
        check_image();
        $display("test restart done");
        errWord = 6'h03;
        boot_reset(0);
        wait_err(2'h1);
        errWord = 6'h3F;
        sw_reset();
        wait_boot(1);
        check_image();
        $display("test bus error done");
        badRead = 1'b1;
        boot_reset(0);
        wait_err(2'h2);
        badRead = 1'b0;
        $display("test read-back done");
        boot_reset(1);
        wait_boot(0);
        chk(32'(nTr), 32'h0, "no transfers");
        chk(32'(frames), 32'h0, "no frames");
        pass_through();
        $display("test debug done");
        for (int r = 0; r < 2; r++) begin
            @(negedge clk);
            fresh(1);
            if (r == 0) power_on_reset_n = 1'b0;
            else external_reset_n = 1'b0;
            repeat (4) @(negedge clk);
            chk(32'(cpu_reset_n), 32'h0, "async reset");
            power_on_reset_n = 1'b1;
            external_reset_n = 1'b1;
            wait_boot(1);
            check_image();
        end
        $display("test async resets done");
        end_sim();
    end

    // All tests together take well under this span
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        end_sim();
    end
endmodule

// *** sbc_partner.sv ***
// Purpose: Far-side model: serial flash image store and bus memory
// Assumes: Flash mode 0, data bytes low byte first, bits MSB first
// Notes: Bus waits and faults are set by the bench through ports
`timescale 1ns/1ps
module sbc_partner (
    input wire logic clk, // Bus clock
    input wire logic HRESETN, // Bus reset
    input wire logic [31:0] HADDR, // Bus address
    input wire logic [31:0] HWDATA, // Bus write data
    input wire logic HWRITE, // Bus write
    input wire logic [1:0] HTRANS, // Bus transfer type
    output logic [31:0] HRDATA, // Bus read data
    output logic HREADY, // Bus ready
    output logic HRESP, // Bus error response
    input wire logic slow, // Insert wait states
    input wire logic [5:0] errWord, // Word answered with error
    input wire logic badRead, // Corrupt read data
    input wire logic flash_mosi_out, // Data into flash
    input wire logic flash_cs_n, // Flash select
    input wire logic flash_sck, // Flash clock
    output logic flash_miso_in // Data from flash
);
    logic [31:0] rom [0:15];
    logic [31:0] ram [0:15];
    logic [31:0] sr, lastCmd, dAddr;
    logic [3:0] romIdx;
    logic dAct, dWr, err, errStep;
    logic [1:0] waits, cnt;
    int nBits;

    // Two-cycle error response, as the bus protocol asks
    assign HREADY = !dAct || (waits == 2'h0 && (!err || errStep));
    assign HRESP = dAct && err && waits == 2'h0;
    // Outside a read data phase the data is wrong on purpose
    assign HRDATA = (dAct && !dWr) ? ram[dAddr[5:2]] ^ {31'h0, badRead}
                                   : ~ram[dAddr[5:2]];

    always @(posedge clk) begin
        if (!HRESETN) begin
            dAct <= 1'b0;
            dAddr <= 32'h0;
            waits <= 2'h0;
            cnt <= 2'h0;
            err <= 1'b0;
        end else if (HREADY) begin
            if (dAct && dWr) ram[dAddr[5:2]] <= HWDATA;
            dAct <= HTRANS == 2'h2;
            dAddr <= HADDR;
            dWr <= HWRITE;
            err <= HADDR[7:2] == errWord;
            errStep <= 1'b0;
            cnt <= cnt + 2'h1;
            waits <= slow ? cnt : 2'h0;
        end else if (waits != 2'h0) begin
            waits <= waits - 2'h1;
        end else begin
            errStep <= 1'b1;
        end
    end

    initial flash_miso_in = 1'b0;
    always @(negedge flash_cs_n) nBits = 0;
    always @(posedge flash_sck) begin
        if (flash_cs_n === 1'b0) begin
            sr = {sr[30:0], flash_mosi_out};
            nBits++;
            if (nBits == 32) begin
                lastCmd = sr;
                romIdx = sr[5:2];
            end
        end
    end
    // Shifts on the falling clock so data is steady at the next rise
    always @(negedge flash_sck) begin
        if (flash_cs_n === 1'b0 && nBits >= 32 && nBits < 64) begin
            flash_miso_in = rom[romIdx][8 * ((nBits - 32) / 8) + 7
                                        - (nBits - 32) % 8];
        end
    end
    // Deselected flash lets go: show the inverse of the last bit
    always @(posedge flash_cs_n) flash_miso_in = ~flash_miso_in;
endmodule

// *** sbc_pkg.sv ***
// Purpose: Shared constants and types for the SPI boot copy port block
// Assumes: 25 MHz system clock, separate link clock for the flash shifter
// Notes: Image placement values are plain defaults, set per system
package sbc_pkg;
    localparam logic [31:0] SBC_SPI_SRC_ADDR = 32'h0000_0000;
    localparam logic [31:0] SBC_AHB_DST_ADDR = 32'h0000_0000;
    localparam logic [15:0] SBC_IMAGE_WORDS = 16'h0010;
    localparam logic [31:0] SBC_ADDR_STEP = 32'h0000_0004;
    localparam logic [15:0] SBC_RECOVERY_CYCLES = 16'h0008;
    localparam logic [31:0] SBC_DESELECT_CYCLES = 32'h0000_0008;
    localparam logic [3:0] SBC_SCK_HALF = 4'h4;
    localparam logic [7:0] SBC_READ_CMD = 8'h03;
    localparam logic [6:0] SBC_FRAME_LAST = 7'h3F;
    localparam logic [1:0] SBC_HTRANS_IDLE = 2'h0;
    localparam logic [1:0] SBC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] SBC_HSIZE_WORD = 3'h2;
    localparam logic [2:0] SBC_HBURST_SINGLE = 3'h0;
    localparam logic [1:0] SBC_ERR_RESET = 2'h0;
    localparam logic [31:0] SBC_WORD_RESET = 32'h0000_0000;

    typedef enum logic [3:0] {
        ST_RESET, ST_RECOVER, ST_FETCH, ST_WADDR, ST_WDATA,
        ST_RADDR, ST_RDATA, ST_NEXT, ST_DONE, ST_ERROR
    } sbc_state_t;

    typedef enum logic [1:0] {
        LK_IDLE, LK_SHIFT, LK_DESEL
    } sbc_link_state_t;
endpackage

// *** sbc_sync.sv ***
// Purpose: Two-stage level synchroniser, one bit per lane
// Assumes: Inputs are levels or toggles, never single pulses
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module sbc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // Destination clock
    input wire logic [WIDTH-1:0] d, // Asynchronous levels
    output logic [WIDTH-1:0] q // Synchronised levels
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        stage1 <= d;
        q <= stage1;
    end
endmodule
